// ### rtl/fsl_defines.svh
/*
 * constants for the frame-sync, lock alarm and status pin block:
 * reset values, three-level codes and decoded rate levels.
 * assumes it is included once per compilation unit by bare name.
 */
`ifndef FSL_DEFINES_SVH
`define FSL_DEFINES_SVH

// ---------------------------------------------------------------
// three-level pin codes: {high_seen, low_seen}
// ---------------------------------------------------------------
`define FSL_LVL_LOW 2'h1
`define FSL_LVL_HIGH 2'h2
`define FSL_LVL_MID 2'h0

// ---------------------------------------------------------------
// decoded rate levels
// ---------------------------------------------------------------
`define FSL_RATE_L 2'h0
`define FSL_RATE_M 2'h1
`define FSL_RATE_H 2'h2

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define FSL_RST_ACTIVE 4'h0
`define FSL_RST_RATE 2'h1
// alarm pin and status start in the unlocked sense
`define FSL_RST_ALARM 1'h1
`define FSL_RST_UNLOCKED 1'h1

`endif

// ### rtl/fsl_pkg.sv
/*
 * types shared by the frame-sync and status pin block.
 * assumes fsl_defines.svh is available on the include path.
 */
package fsl_pkg;

   // ------------------------------------------------------------
   // pin groups
   // ------------------------------------------------------------
   // tri-state output pin as value and output enable
   typedef struct packed {
      logic out;
      logic oe;
   } fsl_pin_type;

   // three-level input sensed as two comparators
   typedef struct packed {
      logic high_seen;
      logic low_seen;
   } fsl_tri_type;

   // whole state of the block
   typedef struct packed {
      logic [1:0] realign_s;
      logic [1:0] realign_bit_s;
      logic [1:0] sel_s;
      logic [1:0] mode_s;
      logic [1:0] lock_s;
      logic [3:0] act_s0;
      logic [3:0] act_s1;
      logic [1:0] r0_s0;
      logic [1:0] r0_s1;
      logic [1:0] r1_s0;
      logic [1:0] r1_s1;
      logic realign_out;
      logic sync_of_one;
      logic sync_of_two;
      logic lock_status;
      fsl_pin_type lock_pin;
      logic [3:0] act_status;
      logic [3:0] act_out;
      logic [3:0] act_oe;
      logic [1:0] rate_low;
      logic [1:0] rate_high;
   } fsl_state_type;

endpackage

// ### rtl/fsl_pins.sv
/*
 * frame-sync realign request, clock pairing, lock alarm, active
 * indicators and reference rate decode for the clock multiplier.
 * assumes all pin inputs are asynchronous to clock; the analog
 * loop supplies pll_locked and the input monitor supplies the
 * active-input vector, also treated as asynchronous.
 */
`timescale 1ns/1ps
`include "fsl_defines.svh"

module fsl_pins
   import fsl_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic resetn,
   // realign control
   input wire logic sync_realign_input,
   input wire logic realign_register_bit,
   input wire logic realign_pin_control_select,
   input wire logic clock_pairing_mode_bit,
   output logic realign_request,
   // frame-sync pairing: high when input three / four is a sync
   output logic sync_for_input_one,
   output logic sync_for_input_two,
   // lock alarm
   input wire logic pll_locked,
   input wire logic lock_alarm_pin_enable,
   input wire logic lock_alarm_polarity,
   output logic lock_alarm_output,
   output logic lock_alarm_output_oe,
   output logic lock_status_bit,
   // active clock indicators, one bit per clock input
   input wire logic [3:0] input_is_active,
   input wire logic [3:0] input_active_pin_enable,
   input wire logic input_active_polarity,
   output logic [3:0] input_active_indicator,
   output logic [3:0] input_active_indicator_oe,
   output logic [3:0] input_active_status_bit,
   // reference rate selects, three-level
   input wire fsl_tri_type reference_rate_select_low,
   input wire fsl_tri_type reference_rate_select_high,
   output logic [1:0] rate_low_level,
   output logic [1:0] rate_high_level
);

   fsl_state_type state_reg;
   fsl_state_type state_next;

   // ------------------------------------------------------------
   // three-level decode
   // ------------------------------------------------------------
   // neither comparator tripped means the pin floats mid-rail
   function automatic logic [1:0] decode_level(input logic [1:0] t);
      logic [1:0] lvl;
      lvl = `FSL_RATE_M;
      if (t == `FSL_LVL_LOW) begin
         lvl = `FSL_RATE_L;
      end else if (t == `FSL_LVL_HIGH) begin
         lvl = `FSL_RATE_H;
      end
      return lvl;
   endfunction

   // ------------------------------------------------------------
   // next-state logic
   // ------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      // two-stage synchronisers; stage 0 feeds only stage 1
      state_next.realign_s = {state_reg.realign_s[0],
         sync_realign_input};
      state_next.realign_bit_s = {state_reg.realign_bit_s[0],
         realign_register_bit};
      state_next.sel_s = {state_reg.sel_s[0],
         realign_pin_control_select};
      state_next.mode_s = {state_reg.mode_s[0],
         clock_pairing_mode_bit};
      state_next.lock_s = {state_reg.lock_s[0], pll_locked};
      state_next.act_s0 = input_is_active;
      state_next.act_s1 = state_reg.act_s0;
      state_next.r0_s0 = reference_rate_select_low;
      state_next.r0_s1 = state_reg.r0_s0;
      state_next.r1_s0 = reference_rate_select_high;
      state_next.r1_s1 = state_reg.r1_s0;
      // realign is a level request, only in pairing mode;
      // the source follows the pin-control select
      if (state_reg.mode_s[1]) begin
         if (state_reg.sel_s[1]) begin
            state_next.realign_out = state_reg.realign_s[1];
         end else begin
            state_next.realign_out =
               state_reg.realign_bit_s[1];
         end
      end else begin
         state_next.realign_out = 1'b0;
      end
      // pairing: inputs three and four become sync inputs
      state_next.sync_of_one = state_reg.mode_s[1];
      state_next.sync_of_two = state_reg.mode_s[1];
      // lock status: high means unlocked, regardless of pin enable
      state_next.lock_status = ~state_reg.lock_s[1];
      // lock alarm pin: polarity bit inverts the default sense
      state_next.lock_pin.out = ~state_reg.lock_s[1]
         ^ lock_alarm_polarity;
      state_next.lock_pin.oe = lock_alarm_pin_enable;
      // active indicators, status always kept
      state_next.act_status = state_reg.act_s1;
      state_next.act_out = state_reg.act_s1
         ^ {4{~input_active_polarity}};
      state_next.act_oe = input_active_pin_enable;
      // reference rate decode from synchronised comparators
      state_next.rate_low = decode_level(state_reg.r0_s1);
      state_next.rate_high = decode_level(state_reg.r1_s1);
   end

   // ------------------------------------------------------------
   // state register
   // ------------------------------------------------------------
   // synchronous reset; every field takes a constant
   always_ff @(posedge clock) begin
      if (!resetn) begin
         state_reg <= '0;
         state_reg.lock_pin.out <= `FSL_RST_ALARM;
         state_reg.lock_status <= `FSL_RST_UNLOCKED;
         state_reg.act_status <= `FSL_RST_ACTIVE;
         state_reg.rate_low <= `FSL_RST_RATE;
         state_reg.rate_high <= `FSL_RST_RATE;
      end else begin
         state_reg <= state_next;
      end
   end

   // ------------------------------------------------------------
   // outputs, each straight from a flip-flop
   // ------------------------------------------------------------
   assign realign_request = state_reg.realign_out;
   assign sync_for_input_one = state_reg.sync_of_one;
   assign sync_for_input_two = state_reg.sync_of_two;
   assign lock_alarm_output = state_reg.lock_pin.out;
   assign lock_alarm_output_oe = state_reg.lock_pin.oe;
   assign lock_status_bit = state_reg.lock_status;
   assign input_active_status_bit = state_reg.act_status;
   assign input_active_indicator = state_reg.act_out;
   assign input_active_indicator_oe = state_reg.act_oe;
   assign rate_low_level = state_reg.rate_low;
   assign rate_high_level = state_reg.rate_high;

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   sequence s_pin_path;
      state_reg.mode_s[1] && state_reg.sel_s[1];
   endsequence

   sequence s_reg_path;
      state_reg.mode_s[1] && !state_reg.sel_s[1];
   endsequence

   a_realign_pin_path: assert property (@(posedge clock)
      disable iff (!resetn) s_pin_path |=>
      realign_request == $past(state_reg.realign_s[1]))
      else $error("realign does not follow synchronised pin");

   a_realign_reg_path: assert property (@(posedge clock)
      disable iff (!resetn) s_reg_path |=>
      realign_request == $past(state_reg.realign_bit_s[1]))
      else $error("realign does not follow register bit");

   a_realign_mode_off: assert property (@(posedge clock)
      disable iff (!resetn) !state_reg.mode_s[1] |=> !realign_request)
      else $error("realign outside pairing mode");

   a_pair_three_one: assert property (@(posedge clock)
      disable iff (!resetn)
      $rose(state_reg.mode_s[1]) |=> sync_for_input_one)
      else $error("input three not paired");

   // judged against the synchronised mode, not the sibling output
   a_pair_four_two: assert property (@(posedge clock)
      disable iff (!resetn)
      ##1 sync_for_input_two == $past(state_reg.mode_s[1]))
      else $error("input four pairing does not follow mode");

   a_lock_pin_level: assert property (@(posedge clock)
      disable iff (!resetn) ##1 lock_alarm_output ==
      ($past(lock_alarm_polarity) ^ lock_status_bit))
      else $error("lock alarm level wrong");

   a_lock_pin_tri: assert property (@(posedge clock)
      disable iff (!resetn)
      !lock_alarm_pin_enable |=> !lock_alarm_output_oe)
      else $error("lock alarm driven while disabled");

   // an enabled alarm pin must be driven on the next edge
   a_lock_pin_drive: assert property (@(posedge clock)
      disable iff (!resetn)
      lock_alarm_pin_enable |=> lock_alarm_output_oe)
      else $error("lock alarm not driven while enabled");

   a_lock_status_lat: assert property (@(posedge clock)
      disable iff (!resetn)
      $fell(pll_locked) |-> ##3 lock_status_bit)
      else $error("lock status not updated in three cycles");

   a_pol_flip: assert property (@(posedge clock)
      disable iff (!resetn) $changed(lock_alarm_polarity)
      && $stable(state_reg.lock_s[1]) |=> $changed(lock_alarm_output))
      else $error("polarity change not seen on alarm");

   a_active_oe: assert property (@(posedge clock)
      disable iff (!resetn)
      ##1 input_active_indicator_oe == $past(input_active_pin_enable))
      else $error("active indicator enable wrong");

   // status bits follow the synchronised inputs whatever the enables
   a_active_status: assert property (@(posedge clock)
      disable iff (!resetn)
      ##1 input_active_status_bit == $past(state_reg.act_s1))
      else $error("active status does not follow input");

   a_rate_float_mid: assert property (@(posedge clock)
      disable iff (!resetn)
      (reference_rate_select_low == `FSL_LVL_MID)[*3] |=>
      rate_low_level == `FSL_RATE_M)
      else $error("floating rate pin not middle");

endmodule

// ### sim/fsl_board.sv
/*
 board-side model: drives the realign pin and the three-level rate pins.
 assumes clock is the device clock and the bench changes wants on it.
*/
`timescale 1ns/1ps

module fsl_board
   import fsl_pkg::*;
(
   // clock
   input wire logic clock,
   // levels wanted by the bench
   input wire logic realign_want,
   input wire logic [1:0] rate_low_want,
   input wire logic [1:0] rate_high_want,
   // pins toward the device
   output logic sync_realign_input,
   output fsl_tri_type reference_rate_select_low,
   output fsl_tri_type reference_rate_select_high
);
   int held = 0; // cycles the pin has kept its level

   // ------------------------------------------------------------
   // realign pin
   // ------------------------------------------------------------
   initial sync_realign_input = 1'b0;
   // a level must stand four cycles before it may move again
   always @(posedge clock) begin
      if (realign_want != sync_realign_input && held >= 4) begin
         sync_realign_input <= realign_want;
         held <= 1;
      end else begin
         held <= held + 1;
      end
   end

   // ------------------------------------------------------------
   // three-level pins
   // ------------------------------------------------------------
   // code 3 leaves the pin open; pull-up and pull-down give middle
   function automatic fsl_tri_type tri_level(input logic [1:0] w);
      case (w)
         2'h0: return 2'h1; // driven low
         2'h2: return 2'h2; // driven high
         default: return 2'h0; // middle or floating
      endcase
   endfunction
   assign reference_rate_select_low = tri_level(rate_low_want);
   assign reference_rate_select_high = tri_level(rate_high_want);
endmodule

// ### sim/testbench.sv
/*
 self-checking bench for the frame-sync and status pin block.
 assumes fsl_pins and the board model fsl_board are compiled before.
*/
`timescale 1ns/1ps

module testbench
   import fsl_pkg::*;
;
   logic clock = 1'b0, resetn = 1'b0;
   logic realign_want = 1'b0, realign_register_bit = 1'b0;
   logic realign_pin_control_select = 1'b0, clock_pairing_mode_bit = 1'b0;
   logic pll_locked = 1'b0, lock_alarm_pin_enable = 1'b0;
   logic lock_alarm_polarity = 1'b0, input_active_polarity = 1'b0;
   logic [3:0] input_is_active = 4'h0, input_active_pin_enable = 4'h0;
   logic [1:0] rate_low_want = 2'h3, rate_high_want = 2'h3;
   logic sync_realign_input, realign_request, sync_for_input_one;
   logic sync_for_input_two, lock_alarm_output, lock_alarm_output_oe;
   logic lock_status_bit;
   fsl_tri_type reference_rate_select_low, reference_rate_select_high;
   logic [3:0] input_active_indicator, input_active_indicator_oe;
   logic [3:0] input_active_status_bit;
   logic [1:0] rate_low_level, rate_high_level;
   int n_errors = 0, total_checks = 0;

   initial forever #4 clock = ~clock;

   fsl_pins u_fsl_pins (.clock, .resetn, .sync_realign_input,
      .realign_register_bit, .realign_pin_control_select,
      .clock_pairing_mode_bit, .realign_request, .sync_for_input_one,
      .sync_for_input_two, .pll_locked, .lock_alarm_pin_enable,
      .lock_alarm_polarity, .lock_alarm_output, .lock_alarm_output_oe,
      .lock_status_bit, .input_is_active, .input_active_pin_enable,
      .input_active_polarity, .input_active_indicator,
      .input_active_indicator_oe, .input_active_status_bit,
      .reference_rate_select_low, .reference_rate_select_high,
      .rate_low_level, .rate_high_level);
   fsl_board u_fsl_board (.clock, .realign_want, .rate_low_want,
      .rate_high_want, .sync_realign_input, .reference_rate_select_low,
      .reference_rate_select_high);

   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   task check(input logic [3:0] seen, input logic [3:0] exp, input string s);
      total_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value at %0t: %s", $time, s);
      end
   endtask
   // realign pin changes need three edges plus the board's own edge; the rate pins need only the three
   task settle(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task print_verdict;
      $display("checks %0d, mismatches %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   // every select, mode, pin and bit combination
   task t_realign;
      for (int i = 0; i < 16; i++) begin
         @(posedge clock);
         {clock_pairing_mode_bit, realign_pin_control_select, realign_want,
            realign_register_bit} <= i[3:0];
         settle(6);
         check(realign_request, i[3] & (i[2] ? i[1] : i[0]),
            "realign");
         check(sync_for_input_one, i[3], "pair one");
         check(sync_for_input_two, i[3], "pair two");
      end
      $display("test realign done");
   endtask
   // enable, polarity and lock state in all eight mixes
   task t_lock;
      for (int i = 0; i < 8; i++) begin
         @(posedge clock);
         {lock_alarm_pin_enable, lock_alarm_polarity, pll_locked} <= i[2:0];
         settle(4);
         check(lock_status_bit, !i[0], "lock status");
         check(lock_alarm_output_oe, i[2], "alarm enable");
         if (i[2]) begin
            check(lock_alarm_output, !i[0] ^ i[1], "alarm");
         end
      end
      $display("test lock done");
   endtask
   // disabled indicator pins are only judged on their enable
   task t_active;
      logic [3:0] act, en;
      logic pol;
      for (int i = 0; i < 4; i++) begin
         act = i[0] ? 4'h5 : 4'hA;
         en = i[1] ? 4'h3 : 4'hC;
         pol = i[0] ^ i[1];
         @(posedge clock);
         input_is_active <= act;
         input_active_pin_enable <= en;
         input_active_polarity <= pol;
         settle(4);
         check(input_active_status_bit, act, "active status");
         check(input_active_indicator_oe, en, "active enable");
         check(input_active_indicator & en, (pol ? act : ~act) & en,
            "active pin");
      end
      $display("test active done");
   endtask
   // low, middle, high and open on both rate pins
   task t_rate;
      for (int i = 0; i < 16; i++) begin
         @(posedge clock);
         rate_low_want <= i[1:0];
         rate_high_want <= i[3:2];
         settle(4);
         check(rate_low_level, (i[1:0] == 3) ? 2'h1 : i[1:0],
            "rate low");
         check(rate_high_level, (i[3:2] == 3) ? 2'h1 : i[3:2],
            "rate high");
      end
      $display("test rate done");
   endtask

   // ------------------------------------------------------------
   // main sequence and watchdog
   // ------------------------------------------------------------
   initial begin
      settle(3);
      check(realign_request, 4'h0, "reset realign");
      check(lock_alarm_output, 4'h1, "reset alarm");
      check(lock_alarm_output_oe, 4'h0, "reset alarm enable");
      check(lock_status_bit, 4'h1, "reset status");
      check(input_active_indicator_oe, 4'h0, "reset active enable");
      check(rate_low_level, 4'h1, "reset rate");
      $display("test reset done");
      @(posedge clock) resetn <= 1'b1;
      t_realign;
      t_lock;
      t_active;
      t_rate;
      print_verdict;
   end
   initial begin
      repeat (3000) @(posedge clock);
      n_errors++;
      print_verdict;
   end
endmodule
